// *** hw/spz_pkg.sv ***
// constants shared by both ends of serial port zero
// assumes the core clock is the oscillator clock
package spz_pkg;
  // ------------------------------------------------------------
  // device register map and bit fields
  // ------------------------------------------------------------
  localparam int SPZ_AW = 8;
  localparam logic [7:0] SPZ_SC_ADDR = 8'h98;
  localparam logic [7:0] SPZ_SD_ADDR = 8'h99;
  localparam logic [7:0] SPZ_PC_ADDR = 8'h87;
  localparam logic [7:0] SPZ_IM_ADDR = 8'h9a;
  localparam logic [7:0] SPZ_UNIMP = 8'hff;
  localparam logic [5:0] SPZ_PC_UNIMP = 6'h3f;
  localparam logic [5:0] SPZ_IM_UNIMP = 6'h3f;
  localparam int SC_HI = 7;
  localparam int SC_LO = 6;
  localparam int SC_MP = 5;
  localparam int SC_REN = 4;
  localparam int SC_TB = 3;
  localparam int SC_RB = 2;
  localparam int SC_TD = 1;
  localparam int SC_RD = 0;
  localparam int PC_DBL = 7;
  localparam int PC_FCE = 6;
  localparam logic [1:0] SPZ_M_SYNC = 2'h0;
  localparam logic [1:0] SPZ_M_A10 = 2'h1;
  localparam logic [1:0] SPZ_M_F11 = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SPZ_CLK_HZ = 40_000_000;
  localparam int SPZ_OSC_HZ = 40_000_000;
  localparam int SPZ_CPT = SPZ_CLK_HZ / SPZ_OSC_HZ;
  localparam int SPZ_M0_SLOW_TCLK = 12;
  localparam int SPZ_M0_FAST_TCLK = 4;
  localparam int SPZ_M2_SLOW_TCLK = 64;
  localparam int SPZ_M2_FAST_TCLK = 32;
  localparam int SPZ_OVS = 16;
  localparam logic [3:0] SPZ_M0_SLOW = 4'(SPZ_M0_SLOW_TCLK * SPZ_CPT);
  localparam logic [3:0] SPZ_M0_FAST = 4'(SPZ_M0_FAST_TCLK * SPZ_CPT);
  localparam logic [1:0] SPZ_M2_SLOW_PRE = 2'(SPZ_M2_SLOW_TCLK * SPZ_CPT / SPZ_OVS - 1);
  localparam logic [1:0] SPZ_M2_FAST_PRE = 2'(SPZ_M2_FAST_TCLK * SPZ_CPT / SPZ_OVS - 1);
  localparam logic [3:0] SPZ_OVS_LAST = 4'(SPZ_OVS - 1);
  localparam logic [3:0] SPZ_MID = 4'(SPZ_OVS / 2 - 1);
  localparam logic [3:0] SPZ_BITS10 = 4'd10;
  localparam logic [3:0] SPZ_BITS11 = 4'd11;
  localparam logic [3:0] SPZ_M0_LAST = 4'd7;
  // ------------------------------------------------------------
  // partner wishbone map
  // ------------------------------------------------------------
  localparam logic [7:0] SPZ_P_CTRL = 8'h00;
  localparam logic [7:0] SPZ_P_DIV = 8'h04;
  localparam logic [7:0] SPZ_P_TXD = 8'h08;
  localparam logic [7:0] SPZ_P_RXD = 8'h0c;
  localparam logic [7:0] SPZ_P_STAT = 8'h10;
  localparam logic [7:0] SPZ_P_MASK = 8'h14;
  localparam logic [15:0] SPZ_P_DIV_RST = 16'h0040;
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int ST_FE = 2;
endpackage : spz_pkg

// *** hw/spz_link_if.sv ***
// serial line between the port and its partner
// assumes a pull-up on the data line when nobody drives it
interface spz_link_if;
  logic dev_txd;
  logic dev_rxd;
  logic dev_rxd_oe_n;
  logic ptn_rxd;
  logic ptn_rxd_oe_n;
  logic txd_line;
  logic rxd_line;
  // ------------------------------------------------------------
  // line resolution; the port wins a clash
  // ------------------------------------------------------------
  assign txd_line = dev_txd;
  assign rxd_line = !dev_rxd_oe_n ? dev_rxd : (!ptn_rxd_oe_n ? ptn_rxd : 1'b1);
  modport dev (output dev_txd, output dev_rxd, output dev_rxd_oe_n, input rxd_line);
  modport ptn (output ptn_rxd, output ptn_rxd_oe_n, input txd_line, input rxd_line);
endinterface : spz_link_if

// *** hw/spz_device.sv ***
// serial port zero, device end, with its direct register port
// assumes baud_tick_i is a one-cycle pulse from a timer on clk_i
module spz_device (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [spz_pkg::SPZ_AW-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic baud_tick_i,
  output logic irq_o,
  spz_link_if.dev lnk
);
  import spz_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SOUT, TX_SIN} spz_tx_st_t;
  typedef enum logic {RX_IDLE, RX_FRAME} spz_rx_st_t;
  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic filter;
    logic rxen;
    logic tx9;
    logic rx9;
    logic tdone;
    logic rdone;
    logic fe;
    logic doubler;
    logic fce;
    logic [1:0] imask;
    logic [7:0] rbuf;
    logic [7:0] rdata;
    logic irq;
    logic [1:0] sdiv;
    logic s1;
    logic s2;
    logic s3;
    spz_tx_st_t tx_st;
    logic [10:0] sh;
    logic [3:0] bitn;
    logic [3:0] cnt;
    logic [3:0] ph;
    logic txd;
    logic rxd_o;
    logic rxd_oe_n;
    spz_rx_st_t rx_st;
    logic [3:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
  } spz_dev_state_t;

  spz_dev_state_t s;
  spz_dev_state_t n;
  logic [1:0] mode;
  logic stick;
  logic [3:0] nbits;
  logic [3:0] per;
  logic ninth;
  logic wr_sc;
  logic wr_sd;
  logic wr_pc;
  logic wr_im;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    n = s;
    ninth = 1'b0;
    stick = 1'b0;
    mode = {s.mode_hi, s.mode_lo};
    nbits = (mode == SPZ_M_A10) ? SPZ_BITS10 : SPZ_BITS11;
    per = s.filter ? SPZ_M0_FAST : SPZ_M0_SLOW;
    wr_sc = sfr_wr_i && (sfr_addr_i == SPZ_SC_ADDR);
    wr_sd = sfr_wr_i && (sfr_addr_i == SPZ_SD_ADDR);
    wr_pc = sfr_wr_i && (sfr_addr_i == SPZ_PC_ADDR);
    wr_im = sfr_wr_i && (sfr_addr_i == SPZ_IM_ADDR);
    // input pin synchroniser
    n.s1 = lnk.rxd_line;
    n.s2 = s.s1;
    n.s3 = s.s2;
    // sixteen sample ticks per async bit
    if (mode == SPZ_M_F11)
    begin
      if (s.sdiv == (s.doubler ? SPZ_M2_FAST_PRE : SPZ_M2_SLOW_PRE))
      begin
        n.sdiv = 2'h0;
        stick = 1'b1;
      end
      else
        n.sdiv = s.sdiv + 2'h1;
    end
    else if (mode != SPZ_M_SYNC && baud_tick_i)
    begin
      if (s.doubler)
        stick = 1'b1;
      else
      begin
        n.sdiv[0] = ~s.sdiv[0];
        stick = s.sdiv[0];
      end
    end
    // register writes; hardware sets below override a clear
    if (wr_sc)
    begin
      if (s.fce)
        n.fe = sfr_wdata_i[SC_HI];
      else
        n.mode_hi = sfr_wdata_i[SC_HI];
      n.mode_lo = sfr_wdata_i[SC_LO];
      n.filter = sfr_wdata_i[SC_MP];
      n.rxen = sfr_wdata_i[SC_REN];
      n.tx9 = sfr_wdata_i[SC_TB];
      n.rx9 = sfr_wdata_i[SC_RB];
      n.tdone = sfr_wdata_i[SC_TD];
      n.rdone = sfr_wdata_i[SC_RD];
    end
    if (wr_pc)
    begin
      n.doubler = sfr_wdata_i[PC_DBL];
      n.fce = sfr_wdata_i[PC_FCE];
    end
    if (wr_im)
      n.imask = sfr_wdata_i[1:0];
    // shift engine: async transmit, sync transmit and receive
    case (s.tx_st)
      TX_IDLE:
      begin
        n.txd = 1'b1;
        n.rxd_oe_n = 1'b1;
        if (wr_sd)
        begin
          n.bitn = 4'h0;
          n.cnt = 4'h0;
          n.ph = 4'h0;
          n.txd = 1'b0;
          if (mode == SPZ_M_SYNC)
          begin
            n.tx_st = TX_SOUT;
            n.sh = {3'h7, sfr_wdata_i};
            n.rxd_o = sfr_wdata_i[0];
            n.rxd_oe_n = 1'b0;
          end
          else
          begin
            n.tx_st = TX_ASYNC;
            n.sh = {1'b1, (mode == SPZ_M_A10) ? 1'b1 : s.tx9, sfr_wdata_i, 1'b0};
          end
        end
        else if (mode == SPZ_M_SYNC && s.rxen && !s.rdone)
        begin
          n.tx_st = TX_SIN;
          n.bitn = 4'h0;
          n.ph = 4'h0;
          n.txd = 1'b0;
        end
      end
      TX_ASYNC:
      if (stick)
      begin
        n.cnt = s.cnt + 4'h1;
        if (s.cnt == SPZ_OVS_LAST)
        begin
          n.sh = {1'b1, s.sh[10:1]}; // lsb first
          n.bitn = s.bitn + 4'h1;
          n.txd = s.sh[1];
          if (s.bitn + 4'h1 == nbits - 4'h1)
            n.tdone = 1'b1; // stop bit begins
          if (s.bitn + 4'h1 == nbits)
          begin
            n.tx_st = TX_IDLE;
            n.txd = 1'b1;
          end
        end
      end
      TX_SOUT, TX_SIN:
      begin
        n.ph = s.ph + 4'h1;
        if (s.ph == (per >> 1) - 4'h1)
          n.txd = 1'b1; // shift clock rises mid period
        if (s.ph == per - 4'h1)
        begin
          n.ph = 4'h0;
          n.bitn = s.bitn + 4'h1;
          n.txd = 1'b0;
          if (s.tx_st == TX_SOUT)
          begin
            n.sh = {1'b1, s.sh[10:1]};
            n.rxd_o = s.sh[1];
          end
          else
            n.sh[7:0] = {s.s2, s.sh[7:1]};
          if (s.bitn == SPZ_M0_LAST)
          begin
            n.tx_st = TX_IDLE;
            n.txd = 1'b1;
            n.rxd_oe_n = 1'b1;
            if (s.tx_st == TX_SOUT)
              n.tdone = 1'b1;
            else
            begin
              n.rdone = 1'b1;
              n.rbuf = {s.s2, s.sh[7:1]};
            end
          end
        end
        if (s.tx_st == TX_SIN && !s.rxen)
        begin
          n.tx_st = TX_IDLE;
          n.txd = 1'b1;
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    // async receiver, mid-bit sampling
    case (s.rx_st)
      RX_IDLE:
      if (mode != SPZ_M_SYNC && s.rxen && !s.s2 && s.s3)
      begin
        n.rx_st = RX_FRAME;
        n.rcnt = 4'h0;
        n.rbit = 4'h0;
      end
      RX_FRAME:
      if (!s.rxen || mode == SPZ_M_SYNC)
        n.rx_st = RX_IDLE;
      else if (stick)
      begin
        n.rcnt = s.rcnt + 4'h1;
        if (s.rcnt == SPZ_MID)
        begin
          n.rbit = s.rbit + 4'h1;
          if (s.rbit == 4'h0)
          begin
            if (s.s2)
              n.rx_st = RX_IDLE; // false start
          end
          else if (s.rbit == nbits - 4'h1)
          begin
            n.rx_st = RX_IDLE;
            ninth = (mode == SPZ_M_A10) ? s.s2 : s.rsh[8];
            if (!s.filter || ninth)
            begin
              n.rdone = 1'b1; // mid stop bit
              n.rbuf = s.rsh[7:0];
              n.rx9 = ninth;
            end
            if (!s.s2)
              n.fe = 1'b1;
          end
          else
            n.rsh[s.rbit - 4'h1] = s.s2;
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase
    // read data, one cycle after the address
    case (sfr_addr_i)
      SPZ_SC_ADDR: n.rdata = {s.fce ? s.fe : s.mode_hi, s.mode_lo, s.filter, s.rxen,
                              s.tx9, s.rx9, s.tdone, s.rdone};
      SPZ_SD_ADDR: n.rdata = s.rbuf;
      SPZ_PC_ADDR: n.rdata = {s.doubler, s.fce, SPZ_PC_UNIMP};
      SPZ_IM_ADDR: n.rdata = {SPZ_IM_UNIMP, s.imask};
      default: n.rdata = SPZ_UNIMP;
    endcase
    n.irq = |({n.tdone, n.rdone} & n.imask);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.txd <= 1'b1;
      s.rxd_o <= 1'b1;
      s.rxd_oe_n <= 1'b1;
      s.s1 <= 1'b1;
      s.s2 <= 1'b1;
      s.s3 <= 1'b1;
    end
    else
      s <= n;
  end

  // outputs straight from the state register
  assign sfr_rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign lnk.dev_txd = s.txd;
  assign lnk.dev_rxd = s.rxd_o;
  assign lnk.dev_rxd_oe_n = s.rxd_oe_n;
endmodule : spz_device

// *** hw/spz_partner.sv ***
// serial partner end, ordered over a classic wishbone slave
// assumes the device shift clock is slow enough to be synchronised
module spz_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [spz_pkg::SPZ_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  spz_link_if.ptn lnk
);
  import spz_pkg::*;

  typedef enum logic [1:0] {P_IDLE, P_ASYNC, P_ARMED} spz_ptx_st_t;
  typedef enum logic {P_RIDLE, P_RFRAME} spz_prx_st_t;
  typedef struct packed {
    logic [1:0] mode;
    logic tx9;
    logic [15:0] div;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [8:0] rbuf;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic t1;
    logic t2;
    logic t3;
    logic r1;
    logic r2;
    spz_ptx_st_t tx_st;
    logic [10:0] tsh;
    logic [3:0] tbit;
    logic [15:0] tcnt;
    logic line;
    logic oe_n;
    spz_prx_st_t rx_st;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic [2:0] m0cnt;
  } spz_ptn_state_t;

  spz_ptn_state_t s;
  spz_ptn_state_t n;
  logic wr;
  logic rise;
  logic fall;
  logic [3:0] nbits;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.t1 = lnk.txd_line;
    n.t2 = s.t1;
    n.t3 = s.t2;
    n.r1 = lnk.rxd_line;
    n.r2 = s.r1;
    rise = s.t2 && !s.t3;
    fall = !s.t2 && s.t3;
    nbits = (s.mode == SPZ_M_A10) ? SPZ_BITS10 : SPZ_BITS11;
    // ack one cycle after the request, write on the ack edge
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    wr = wb_cyc_i && wb_stb_i && s.ack && wb_we_i && wb_sel_i[0];
    case (wb_adr_i)
      SPZ_P_CTRL: n.dat = {29'h0, s.tx9, s.mode};
      SPZ_P_DIV: n.dat = {16'h0, s.div};
      SPZ_P_RXD: n.dat = {23'h0, s.rbuf};
      SPZ_P_STAT: n.dat = {29'h0, s.stat};
      SPZ_P_MASK: n.dat = {29'h0, s.mask};
      default: n.dat = 32'h0;
    endcase
    if (wr && wb_adr_i == SPZ_P_CTRL)
      {n.tx9, n.mode} = wb_dat_i[2:0];
    if (wr && wb_adr_i == SPZ_P_DIV && wb_sel_i[1])
      n.div = wb_dat_i[15:0];
    if (wr && wb_adr_i == SPZ_P_STAT)
      n.stat = s.stat & ~wb_dat_i[2:0];
    if (wr && wb_adr_i == SPZ_P_MASK)
      n.mask = wb_dat_i[2:0];
    // transmitter toward the device input pin
    case (s.tx_st)
      P_IDLE:
      begin
        n.line = 1'b1;
        n.oe_n = (s.mode == SPZ_M_SYNC);
        if (wr && wb_adr_i == SPZ_P_TXD)
        begin
          n.oe_n = 1'b0;
          n.tbit = 4'h0;
          n.tcnt = 16'h0;
          if (s.mode == SPZ_M_SYNC)
          begin
            n.tx_st = P_ARMED;
            n.tsh = {3'h7, wb_dat_i[7:0]};
            n.line = wb_dat_i[0];
          end
          else
          begin
            n.tx_st = P_ASYNC;
            n.tsh = {1'b1, (s.mode == SPZ_M_A10) ? 1'b1 : s.tx9, wb_dat_i[7:0], 1'b0};
            n.line = 1'b0;
          end
        end
      end
      P_ASYNC:
      begin
        n.tcnt = s.tcnt + 16'h1;
        if (s.tcnt == s.div - 16'h1)
        begin
          n.tcnt = 16'h0;
          n.tsh = {1'b1, s.tsh[10:1]};
          n.tbit = s.tbit + 4'h1;
          n.line = s.tsh[1];
          if (s.tbit + 4'h1 == nbits)
          begin
            n.tx_st = P_IDLE;
            n.line = 1'b1;
            n.stat[ST_TX] = 1'b1;
          end
        end
      end
      P_ARMED:
      begin
        // next bit after the device sampled, skipping the first fall
        if (fall && s.m0cnt != 3'h0)
        begin
          n.tsh = {1'b1, s.tsh[10:1]};
          n.line = s.tsh[1];
        end
        // hold the last bit a while past the 8th rise: the device samples at
        // period end, and our synced rise already trails its shift clock
        if (rise && s.m0cnt == SPZ_M0_LAST[2:0])
          n.tcnt = 16'h1;
        if (s.tcnt != 16'h0)
        begin
          n.tcnt = s.tcnt + 16'h1;
          if (s.tcnt == {12'h0, SPZ_M0_SLOW})
          begin
            n.tx_st = P_IDLE;
            n.oe_n = 1'b1;
            n.stat[ST_TX] = 1'b1;
          end
        end
      end
      default: n.tx_st = P_IDLE;
    endcase
    // receiver: shift clock in mode 0, else async frames
    if (s.mode == SPZ_M_SYNC)
    begin
      n.rx_st = P_RIDLE;
      if (rise)
      begin
        n.m0cnt = s.m0cnt + 3'h1;
        n.rsh[7:0] = {s.r2, s.rsh[7:1]};
        if (s.m0cnt == SPZ_M0_LAST[2:0])
        begin
          n.rbuf = {1'b0, s.r2, s.rsh[7:1]};
          n.stat[ST_RX] = 1'b1;
        end
      end
    end
    else
    begin
      n.m0cnt = 3'h0;
      case (s.rx_st)
        P_RIDLE:
        if (fall)
        begin
          n.rx_st = P_RFRAME;
          n.rcnt = 16'h0;
          n.rbit = 4'h0;
        end
        P_RFRAME:
        begin
          n.rcnt = s.rcnt + 16'h1;
          if (s.rcnt == s.div - 16'h1)
          begin
            n.rcnt = 16'h0;
            n.rbit = s.rbit + 4'h1;
          end
          if (s.rcnt == (s.div >> 1))
          begin
            if (s.rbit == 4'h0)
            begin
              if (s.t2)
                n.rx_st = P_RIDLE;
            end
            else if (s.rbit == nbits - 4'h1)
            begin
              n.rx_st = P_RIDLE;
              n.rbuf = {(s.mode == SPZ_M_A10) ? s.t2 : s.rsh[8], s.rsh[7:0]};
              n.stat[ST_RX] = 1'b1;
              if (!s.t2)
                n.stat[ST_FE] = 1'b1;
            end
            else
              n.rsh[s.rbit - 4'h1] = s.t2;
          end
        end
        default: n.rx_st = P_RIDLE;
      endcase
    end
    n.irq = |(n.stat & n.mask);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.div <= SPZ_P_DIV_RST;
      s.t1 <= 1'b1;
      s.t2 <= 1'b1;
      s.t3 <= 1'b1;
      s.line <= 1'b1;
      s.oe_n <= 1'b1;
    end
    else
      s <= n;
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign irq_o = s.irq;
  assign lnk.ptn_rxd = s.line;
  assign lnk.ptn_rxd_oe_n = s.oe_n;
endmodule : spz_partner

// *** sim/spz_link_asserts.sv ***
// concurrent checks on the serial line joining both ends
// assumes one clock and a synchronous active-high reset
module spz_link_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_txd,
  input wire logic dev_rxd,
  input wire logic dev_rxd_oe_n,
  input wire logic ptn_rxd,
  input wire logic ptn_rxd_oe_n,
  input wire logic txd_line,
  input wire logic rxd_line
);
  logic [7:0] run;
  logic [3:0] nfall;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  // run saturates so a long idle level never wraps to a legal length
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run <= 8'h00;
      nfall <= 4'h0;
    end
    else
    begin
      run <= $changed(dev_txd) ? 8'h01 : (run == 8'hff ? run : run + 8'h01);
      nfall <= dev_txd && dev_rxd_oe_n ? 4'h0 : nfall + 4'($fell(dev_txd));
    end
  end
  // ------------------------------------------------------------
  // line properties
  // ------------------------------------------------------------
  reset_idle_a: assert property ($fell(rst_i) |-> dev_txd && dev_rxd_oe_n && ptn_rxd_oe_n)
    else $error("line not idle after reset");
  line_resolve_a: assert property (txd_line == dev_txd
    && rxd_line == (!dev_rxd_oe_n ? dev_rxd : (!ptn_rxd_oe_n ? ptn_rxd : 1'b1)))
    else $error("line level wrong");
  drive_start_a: assert property ($fell(dev_rxd_oe_n) |-> $fell(dev_txd))
    else $error("shift data driven off period start");
  no_clash_a: assert property (!(!dev_rxd_oe_n && !ptn_rxd_oe_n))
    else $error("both ends drive data line");
  data_edge_a: assert property (!dev_rxd_oe_n && $past(!dev_rxd_oe_n) && $changed(dev_rxd)
    |-> $fell(dev_txd))
    else $error("shift data moved off period start");
  low_half_a: assert property ($rose(dev_txd) && !dev_rxd_oe_n && $past(!dev_rxd_oe_n)
    |-> run == 8'd2 || run == 8'd6)
    else $error("shift clock low half wrong");
  high_half_a: assert property ($fell(dev_txd) && !dev_rxd_oe_n && $past(!dev_rxd_oe_n)
    |-> run == 8'd2 || run == 8'd6)
    else $error("shift clock high half wrong");
  frame_bits_a: assert property ($rose(dev_rxd_oe_n) |-> nfall == 4'd8)
    else $error("shift frame not eight bits");
endmodule : spz_link_asserts

// *** sim/serial_port_zero_tb.sv ***
// self-checking bench: device and partner joined by the link interface
// assumes the design files of both ends and the package compile first
module serial_port_zero_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spz_pkg::*;
  logic clk_i, rst_i, swr, bt, cyc, stb, we, ack, dirq, pirq, tb9;
  logic [7:0] sa, swd, srd, adr, s;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, v;
  int fails, n_compared, cyc_n;
  spz_link_if spz_link_if_i ();
  spz_device spz_device_i (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sa), .sfr_wr_i(swr),
    .sfr_wdata_i(swd), .sfr_rdata_o(srd), .baud_tick_i(bt), .irq_o(dirq),
    .lnk(spz_link_if_i.dev));
  spz_partner spz_partner_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(pirq), .lnk(spz_link_if_i.ptn));
  spz_link_asserts spz_link_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .dev_txd(spz_link_if_i.dev_txd), .dev_rxd(spz_link_if_i.dev_rxd),
    .dev_rxd_oe_n(spz_link_if_i.dev_rxd_oe_n), .ptn_rxd(spz_link_if_i.ptn_rxd),
    .ptn_rxd_oe_n(spz_link_if_i.ptn_rxd_oe_n), .txd_line(spz_link_if_i.txd_line),
    .rxd_line(spz_link_if_i.rxd_line));
  // ------------------------------------------------------------
  // clock, baud tick and hang guard
  // ------------------------------------------------------------
  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // tick every second clock: 64 clocks a bit in modes 1 and 3
  always @(posedge clk_i)
  begin
    bt <= ~bt;
    cyc_n++;
    if (cyc_n == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sa <= a;
    swd <= d;
    swr <= 1'b1;
    @(posedge clk_i);
    swr <= 1'b0;
  endtask : sw
  // read data is registered, so it is taken one edge after the address
  task sr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sa <= a;
    @(posedge clk_i);
    #1 d = srd;
  endtask : sr
  // classic cycle: held until ack is sampled high, released at that edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk_i iff ack);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask : wb
  task pwait(input int b);
    do wb(1'b0, SPZ_P_STAT, 32'h0, v); while (v[b] !== 1'b1);
  endtask : pwait
  // far end done sending, then past the device's mid stop sample
  task quiet();
    pwait(ST_TX);
    repeat (80) @(posedge clk_i);
  endtask : quiet
  task ptx(input logic [7:0] d);
    wb(1'b1, SPZ_P_STAT, 32'h7, v);
    wb(1'b1, SPZ_P_TXD, {24'h0, d}, v);
  endtask : ptx
  task dtx(input logic [7:0] d, input logic [8:0] e, input logic [8:0] m);
    wb(1'b1, SPZ_P_STAT, 32'h7, v);
    sw(SPZ_SD_ADDR, d);
    pwait(ST_RX);
    wb(1'b0, SPZ_P_RXD, 32'h0, v);
    chk("ptn_rxd", {23'h0, v[8:0] & m}, {23'h0, e});
    chk("ptn_irq", pirq, 1'b1);
    sr(SPZ_SC_ADDR, s);
    chk("tx_done", s[SC_TD], 1'b1);
  endtask : dtx
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_i, swr, bt, cyc, stb, we, sa, swd, adr, sel, wdat} = {1'b1, 65'h0};
    fails = 0;
    n_compared = 0;
    cyc_n = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    sr(SPZ_SC_ADDR, s);
    chk("sc_reset", s, 8'h00);
    sr(SPZ_PC_ADDR, s);
    chk("pc_reset", s, 8'h3f);
    sr(SPZ_IM_ADDR, s);
    chk("im_reset", s, 8'hfc);
    sr(8'h00, s);
    chk("unmapped", s, 8'hff);
    wb(1'b0, SPZ_P_DIV, 32'h0, v);
    chk("div_reset", v, 32'h40);
    wb(1'b0, 8'h20, 32'h0, v);
    chk("ptn_unmapped", v, 32'h0);
    sw(SPZ_IM_ADDR, 8'h03);
    wb(1'b1, SPZ_P_MASK, 32'h1, v);
    // each async mode, both directions; mode 2 sends a zero ninth bit
    for (int m = 1; m < 4; m++)
    begin
      tb9 = (m == 3);
      sw(SPZ_SC_ADDR, {m[1:0], 2'b01, tb9, 3'b000});
      wb(1'b1, SPZ_P_CTRL, {29'h0, tb9, m[1:0]}, v);
      chk("irq_clear", dirq, 1'b0);
      sr(SPZ_SC_ADDR, s);
      chk("mode_bits", s[7:6], m[1:0]);
      dtx(8'ha0 + m[7:0], {(m == 1) | tb9, 8'ha0 + m[7:0]}, 9'h1ff);
      chk("irq_tx", dirq, 1'b1);
      sw(SPZ_SC_ADDR, {m[1:0], 2'b01, tb9, 3'b000});
      ptx(8'h3c + m[7:0]);
      @(posedge clk_i iff dirq);
      sr(SPZ_SD_ADDR, s);
      chk("dev_rx", s, 8'h3c + m[7:0]);
      sr(SPZ_SC_ADDR, s);
      chk("rx_ninth", s[SC_RB], (m == 1) | tb9);
      // far end must finish its stop bit before mode or period change
      pwait(ST_TX);
    end
    // mode 2 with the doubler at 32 clocks a bit
    wb(1'b1, SPZ_P_CTRL, 32'h2, v);
    wb(1'b1, SPZ_P_DIV, 32'h20, v);
    sw(SPZ_PC_ADDR, 8'h80);
    sw(SPZ_SC_ADDR, 8'h90);
    dtx(8'h96, 9'h096, 9'h1ff);
    sw(SPZ_PC_ADDR, 8'h00);
    wb(1'b1, SPZ_P_DIV, 32'h40, v);
    // address filter: zero ninth bit dropped, set ninth bit kept but masked
    sw(SPZ_SC_ADDR, 8'hb0);
    ptx(8'h77);
    quiet();
    sr(SPZ_SC_ADDR, s);
    chk("filter_drop", s[SC_RD], 1'b0);
    sw(SPZ_IM_ADDR, 8'h02);
    wb(1'b1, SPZ_P_CTRL, 32'h6, v);
    ptx(8'h88);
    quiet();
    sr(SPZ_SC_ADDR, s);
    chk("filter_pass", s[SC_RD], 1'b1);
    chk("irq_masked", dirq, 1'b0);
    sw(SPZ_IM_ADDR, 8'h03);
    @(posedge clk_i iff dirq);
    // receiver disabled: line ignored, buffer kept
    sw(SPZ_SC_ADDR, 8'h80);
    ptx(8'h55);
    quiet();
    sr(SPZ_SC_ADDR, s);
    chk("ren_off_flag", s[SC_RD], 1'b0);
    sr(SPZ_SD_ADDR, s);
    chk("ren_off_data", s, 8'h88);
    // mode 1 fed an 11-bit frame with a zero ninth bit: bad stop bit
    sw(SPZ_SC_ADDR, 8'h70);
    sw(SPZ_PC_ADDR, 8'h40);
    wb(1'b1, SPZ_P_CTRL, 32'h2, v);
    ptx(8'h44);
    quiet();
    sr(SPZ_SC_ADDR, s);
    chk("frame_err", s[7], 1'b1);
    chk("bad_stop_drop", s[SC_RD], 1'b0);
    sw(SPZ_SC_ADDR, 8'h70);
    sr(SPZ_SC_ADDR, s);
    chk("frame_err_clr", s[7], 1'b0);
    sw(SPZ_PC_ADDR, 8'h00);
    // mode 0: send at /12, receive at /12, send at /4
    wb(1'b1, SPZ_P_CTRL, 32'h0, v);
    sw(SPZ_SC_ADDR, 8'h00);
    dtx(8'hc3, 9'h0c3, 9'h0ff);
    ptx(8'h69);
    sw(SPZ_SC_ADDR, 8'h10);
    @(posedge clk_i iff dirq);
    sr(SPZ_SD_ADDR, s);
    chk("m0_rx", s, 8'h69);
    // far end lets go of the data line before the device drives it
    pwait(ST_TX);
    sw(SPZ_SC_ADDR, 8'h20);
    dtx(8'h0f, 9'h00f, 9'h0ff);
    chk("m0_fast_done", dirq, 1'b1);
    report_and_stop();
  end
endmodule : serial_port_zero_tb
